// File: verilog/lasp_pkg.sv
// Notes on behaviour
// - latched or transparent address and data, byte mix, combine freely
// - host holds both gates high for purely asynchronous accesses
// - host keeps both byte strobes high during every read
// - host changes address only while both byte strobes are high
// - host keeps address, select and data stable around every gate fall
// - write strobe means either byte strobe; write begins when either falls
`default_nettype none
package lasp_pkg;
	localparam int LASP_AW = 16;
	localparam int LASP_DW = 18;
	localparam int LASP_LANE_W = 9;
	localparam logic [1:0] LASP_LANE_LO = 2'h1;
	localparam logic [1:0] LASP_LANE_HI = 2'h2;
	localparam logic [1:0] LASP_LANE_NONE = 2'h0;
	// phase lengths in core clock cycles (40 ns each covers every min figure)
	localparam logic [3:0] LASP_SETUP_CYC = 4'h1;
	localparam logic [3:0] LASP_STRB_CYC = 4'h1;
	localparam logic [3:0] LASP_READ_CYC = 4'h1;
	localparam logic [3:0] LASP_HOLD_CYC = 4'h1;

	typedef struct packed {
		logic write;
		logic [1:0] lanes;
		logic latch_addr;
		logic latch_data;
		logic [LASP_AW-1:0] addr;
		logic [LASP_DW-1:0] wdata;
	} lasp_req_type;

	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic byt_low_strb_n;
		logic byt_hi_strb_n;
		logic addr_capture_gate;
		logic din_capture_gate;
	} lasp_ctl_type;

	localparam lasp_ctl_type LASP_CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : lasp_pkg
`default_nettype wire

// File: verilog/lasp_rd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage sampler; change accepted when last two stages agree
module lasp_rd_sync #(
	parameter int W = 18
) (
	// clocking
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] q;
	logic [W-1:0] next_q;

	always_comb begin
		next_q = q;
		if (s2 == s3) begin
			next_q = s3;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else if (ce_i) begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

	assign q_o = q;
endmodule : lasp_rd_sync
`default_nettype wire

// File: verilog/lasp_host.sv
`timescale 1ns/1ps
`default_nettype none
module lasp_host
	import lasp_pkg::*;
#(
	parameter logic [3:0] SYNC_CYC = 4'h4
) (
	// clocking
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// request side
	input wire logic req_valid_i,
	input wire lasp_pkg::lasp_req_type req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [lasp_pkg::LASP_DW-1:0] rsp_data_o,
	// memory pins
	output logic [lasp_pkg::LASP_AW-1:0] addr_o,
	output logic chip_sel_n_o,
	output logic out_en_n_o,
	output logic byt_low_strb_n_o,
	output logic byt_hi_strb_n_o,
	output logic addr_capture_gate_o,
	output logic din_capture_gate_o,
	input wire logic [lasp_pkg::LASP_DW-1:0] bus_pins_i,
	output logic [lasp_pkg::LASP_DW-1:0] bus_pins_o,
	output logic bus_pins_oe_o
);
	import lasp_pkg::*;

	// one access at a time; each phase but sync lasts its package count of core clocks, sync lasts SYNC_CYC
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SETUP = 6'h02,
		ST_STRB = 6'h04,
		ST_READ = 6'h08,
		ST_SYNC = 6'h10,
		ST_HOLD = 6'h20
	} lasp_state_type;

	lasp_state_type state;
	lasp_state_type next_state;
	lasp_req_type cur;
	lasp_req_type next_cur;
	lasp_ctl_type ctl;
	lasp_ctl_type next_ctl;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic oe;
	logic next_oe;
	logic rsp_valid;
	logic next_rsp_valid;
	logic [LASP_DW-1:0] rsp_data;
	logic [LASP_DW-1:0] next_rsp_data;
	logic [LASP_DW-1:0] rd_sampled;

	// strobe mask for a lane set; an empty set becomes both lanes
	function automatic logic [1:0] lasp_lanes(input logic [1:0] lanes);
		lasp_lanes = (lanes == LASP_LANE_NONE) ? (LASP_LANE_LO | LASP_LANE_HI) : lanes;
	endfunction : lasp_lanes

	// last cycle of a counted phase
	function automatic logic lasp_phase_end(input logic [3:0] count);
		lasp_phase_end = (count == 4'h1);
	endfunction : lasp_phase_end

	// pins are asynchronous to core_clk_i, so read data is resampled before use
	lasp_rd_sync #(
		.W(LASP_DW)
	) u_rd_sync (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i(bus_pins_i),
		.q_o(rd_sampled)
	);

	// sequencer and pin group: pins move only on a core clock edge or an asynchronous reset
	always_comb begin
		next_state = state;
		next_ctl = ctl;
		next_cnt = cnt;
		next_oe = oe;
		case (state)
			ST_IDLE: begin
				next_ctl = LASP_CTL_IDLE;
				if (req_valid_i) begin
					// address and select presented with both strobes high
					next_ctl.chip_sel_n = 1'b0;
					next_oe = req_i.write;
					next_cnt = LASP_SETUP_CYC;
					next_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				next_cnt = cnt - 4'h1;
				if (lasp_phase_end(cnt)) begin
					// gate falls only after a full setup cycle of stable levels
					next_ctl.addr_capture_gate = !cur.latch_addr;
					next_ctl.din_capture_gate = !(cur.write && cur.latch_data);
					if (cur.write) begin
						// output enable left high through the write
						next_ctl.byt_low_strb_n = !cur.lanes[0];
						next_ctl.byt_hi_strb_n = !cur.lanes[1];
						next_cnt = LASP_STRB_CYC;
						next_state = ST_STRB;
					end else begin
						next_ctl.out_en_n = 1'b0;
						next_cnt = LASP_READ_CYC;
						next_state = ST_READ;
					end
				end
			end
			ST_STRB: begin
				next_cnt = cnt - 4'h1;
				if (lasp_phase_end(cnt)) begin
					// strobes rise before select and data move
					next_ctl.byt_low_strb_n = 1'b1;
					next_ctl.byt_hi_strb_n = 1'b1;
					next_cnt = LASP_HOLD_CYC;
					next_state = ST_HOLD;
				end
			end
			ST_READ: begin
				next_cnt = cnt - 4'h1;
				if (lasp_phase_end(cnt)) begin
					next_cnt = SYNC_CYC;
					next_state = ST_SYNC;
				end
			end
			ST_SYNC: begin
				// pin data takes the sampler's full depth before it is trusted
				next_cnt = cnt - 4'h1;
				if (lasp_phase_end(cnt)) begin
					next_ctl.out_en_n = 1'b1;
					next_cnt = LASP_HOLD_CYC;
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				next_cnt = cnt - 4'h1;
				if (lasp_phase_end(cnt)) begin
					next_ctl = LASP_CTL_IDLE;
					next_oe = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_ctl = LASP_CTL_IDLE;
				next_oe = 1'b0;
				next_state = ST_IDLE;
			end
		endcase
	end

	// ce_i low freezes every group, so a stalled access resumes where it stopped
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= ST_IDLE;
			ctl <= LASP_CTL_IDLE;
			cnt <= 4'h0;
			oe <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			ctl <= next_ctl;
			cnt <= next_cnt;
			oe <= next_oe;
		end
	end

	// request group: loaded only on a take, so the address moves with both strobes high
	always_comb begin
		next_cur = cur;
		if ((state == ST_IDLE) && req_valid_i) begin
			next_cur = req_i;
			next_cur.lanes = lasp_lanes(req_i.lanes);
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur <= '0;
		end else if (ce_i) begin
			cur <= next_cur;
		end
	end

	// response group: one pulse as the sync phase closes
	always_comb begin
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		if ((state == ST_SYNC) && lasp_phase_end(cnt)) begin
			next_rsp_data = rd_sampled;
			next_rsp_valid = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else if (ce_i) begin
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
		end
	end

	assign req_ready_o = (state == ST_IDLE) && ce_i;
	assign rsp_valid_o = rsp_valid;
	assign rsp_data_o = rsp_data;
	assign addr_o = cur.addr;
	assign chip_sel_n_o = ctl.chip_sel_n;
	assign out_en_n_o = ctl.out_en_n;
	assign byt_low_strb_n_o = ctl.byt_low_strb_n;
	assign byt_hi_strb_n_o = ctl.byt_hi_strb_n;
	assign addr_capture_gate_o = ctl.addr_capture_gate;
	assign din_capture_gate_o = ctl.din_capture_gate;
	assign bus_pins_o = cur.wdata;
	// drive data only on writes, never while a read is enabled
	assign bus_pins_oe_o = oe;
endmodule : lasp_host
`default_nettype wire

// File: tb/lasp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lasp_chk
	import lasp_pkg::*;
(
	// clocking
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// request side
	input wire logic req_valid_i,
	input wire lasp_pkg::lasp_req_type req_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	// memory pins
	input wire logic [lasp_pkg::LASP_AW-1:0] addr_o,
	input wire logic chip_sel_n_o,
	input wire logic out_en_n_o,
	input wire logic byt_low_strb_n_o,
	input wire logic byt_hi_strb_n_o,
	input wire logic addr_capture_gate_o,
	input wire logic din_capture_gate_o,
	input wire logic [lasp_pkg::LASP_DW-1:0] bus_pins_o,
	input wire logic bus_pins_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	logic tk;
	logic st;
	assign tk = req_valid_i && req_ready_o;
	assign st = byt_low_strb_n_o && byt_hi_strb_n_o;
	async_gate_a: assert property (
		tk && !req_i.latch_addr && !req_i.latch_data |=> (addr_capture_gate_o && din_capture_gate_o)[*4])
		else $error("gate fell in async access");
	read_strobe_a: assert property (!out_en_n_o |-> st && !bus_pins_oe_o) else $error("strobe in read");
	addr_move_a: assert property ($changed(addr_o) |-> st && $past(st)) else $error("address moved in write");
	addr_hold_a: assert property (
		$fell(addr_capture_gate_o) |-> $stable(addr_o) && $stable(chip_sel_n_o)) else $error("address unstable");
	data_hold_a: assert property ($fell(din_capture_gate_o) |-> $stable(bus_pins_o)) else $error("data unstable");
	lane_low_a: assert property (
		tk && req_i.write && req_i.lanes == LASP_LANE_LO |-> ##2 !byt_low_strb_n_o && byt_hi_strb_n_o)
		else $error("lower lane strobe");
	lane_high_a: assert property (
		tk && req_i.write && req_i.lanes == LASP_LANE_HI |-> ##2 byt_low_strb_n_o && !byt_hi_strb_n_o)
		else $error("upper lane strobe");
	lane_both_a: assert property (
		tk && req_i.write && req_i.lanes == LASP_LANE_NONE |-> ##2 !byt_low_strb_n_o && !byt_hi_strb_n_o)
		else $error("both lane strobe");
	cover property (tk && req_i.write);
	cover property (rsp_valid_o);
	cover property ($fell(addr_capture_gate_o));
endmodule : lasp_chk
`default_nettype wire

// File: tb/lasp_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module lasp_sram_model
	import lasp_pkg::*;
(
	// control pins
	input wire logic [lasp_pkg::LASP_AW-1:0] addr_i,
	input wire logic chip_sel_n_i,
	input wire logic out_en_n_i,
	input wire logic byt_low_strb_n_i,
	input wire logic byt_hi_strb_n_i,
	input wire logic addr_capture_gate_i,
	input wire logic din_capture_gate_i,
	// data pins
	input wire logic [lasp_pkg::LASP_DW-1:0] bus_pins_i,
	output logic [lasp_pkg::LASP_DW-1:0] bus_pins_o,
	output logic bus_pins_oe_o
);
	logic [LASP_DW-1:0] mem [0:65535];
	logic [LASP_AW-1:0] la;
	logic lsel = 1'b1;
	logic [LASP_DW-1:0] ld;
	always @* if (addr_capture_gate_i) begin
		la = addr_i;
		lsel = chip_sel_n_i;
	end
	always @* if (din_capture_gate_i) ld = bus_pins_i;
	always @* if (!lsel) begin
		if (!byt_low_strb_n_i) mem[la][8:0] = ld[8:0];
		if (!byt_hi_strb_n_i) mem[la][17:9] = ld[17:9];
	end
	// off at power up, while deselected and through any write
	assign bus_pins_oe_o = !lsel && !out_en_n_i && byt_low_strb_n_i && byt_hi_strb_n_i;
	assign bus_pins_o = mem[la];
endmodule : lasp_sram_model
`default_nettype wire

// File: tb/tb_latched_address_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_latched_address_sram_port;
	import lasp_pkg::*;
	logic core_clk_i, rstn_i, req_valid_i, ph, req_ready_o, rsp_valid_o, bus_pins_oe_o, chip_sel_n_o, out_en_n_o;
	logic byt_low_strb_n_o, byt_hi_strb_n_o, addr_capture_gate_o, din_capture_gate_o, m_oe, ce_i;
	lasp_req_type req_i;
	logic [LASP_AW-1:0] addr_o;
	logic [LASP_DW-1:0] rsp_data_o, bus_pins_o, m_q, bus_pins_i;
	logic [LASP_DW-1:0] expv [0:7];
	logic [31:0] seed = 32'h000161A4;
	int fails = 0;
	int check_count = 0;
	// released bus toggles every cycle so a stale value cannot pass
	assign bus_pins_i = bus_pins_oe_o ? bus_pins_o : m_oe ? m_q : {9{ph, !ph}};
	lasp_host dut (.core_clk_i, .rstn_i, .ce_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o,
		.rsp_data_o, .addr_o, .chip_sel_n_o, .out_en_n_o, .byt_low_strb_n_o, .byt_hi_strb_n_o,
		.addr_capture_gate_o, .din_capture_gate_o, .bus_pins_i, .bus_pins_o, .bus_pins_oe_o);
	lasp_sram_model ram (.addr_i(addr_o), .chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o),
		.byt_low_strb_n_i(byt_low_strb_n_o), .byt_hi_strb_n_i(byt_hi_strb_n_o),
		.addr_capture_gate_i(addr_capture_gate_o), .din_capture_gate_i(din_capture_gate_o),
		.bus_pins_i(bus_pins_i), .bus_pins_o(m_q), .bus_pins_oe_o(m_oe));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = !core_clk_i;
	end
	always @(posedge core_clk_i) ph <= !ph;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] d, input logic [1:0] ln);
		merge = o;
		if (ln != LASP_LANE_HI) merge[8:0] = d[8:0];
		if (ln != LASP_LANE_LO) merge[17:9] = d[17:9];
	endfunction : merge
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (!ok) begin
			fails++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk
	// the two ends must never drive the shared pins together
	always @(negedge core_clk_i) begin
		if (rstn_i === 1'b1) chk(!(bus_pins_oe_o !== 1'b0 && m_oe !== 1'b0), "bus contention");
	end
	task automatic xfer(input logic w, input logic [2:0] s, input logic [1:0] ln);
		int n;
		logic [17:0] d;
		@(posedge core_clk_i);
		#1;
		seed = xs(seed);
		d = seed[17:0];
		req_i <= '{w, ln, seed[20], seed[21], {13'h1FFF, s}, d};
		req_valid_i <= 1'b1;
		for (n = 0; !req_ready_o && n < 50; n++) begin
			@(posedge core_clk_i);
			#1;
		end
		chk(req_ready_o === 1'b1, "never ready");
		@(posedge core_clk_i);
		#1;
		req_valid_i <= 1'b0;
		if (w) expv[s] = merge(expv[s], d, ln);
		else begin
			for (n = 0; !rsp_valid_o && n < 20; n++) begin
				@(posedge core_clk_i);
				#1;
			end
			chk(rsp_valid_o === 1'b1 && rsp_data_o === expv[s], "read data");
		end
	endtask : xfer
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	initial begin
		ph = 1'b0;
		rstn_i = 1'b0;
		req_valid_i = 1'b0;
		req_i = '0;
		ce_i = 1'b1;
		repeat (8) @(posedge core_clk_i);
		#1 rstn_i = 1'b1;
		chk(bus_pins_oe_o === 1'b0 && chip_sel_n_o === 1'b1, "idle pins");
		for (int i = 0; i < 8; i++) xfer(1'b1, 3'(i), LASP_LANE_NONE);
		for (int i = 0; i < 8; i++) xfer(1'b0, 3'(i), 2'h0);
		$display("test fill done");
		// idle freeze: no request may be taken while the core is held
		@(posedge core_clk_i);
		#1 ce_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1 chk(req_ready_o === 1'b0 && chip_sel_n_o === 1'b1, "ready while frozen");
		ce_i = 1'b1;
		// freeze in mid-read: the answer must still come back intact
		fork
			xfer(1'b0, 3'h2, 2'h0);
			begin
				repeat (3) @(posedge core_clk_i);
				#1 ce_i = 1'b0;
				repeat (4) @(posedge core_clk_i);
				#1 ce_i = 1'b1;
			end
		join
		$display("test freeze done");
		// reset in mid-read: pins fall back to idle at once
		@(posedge core_clk_i);
		#1 req_i <= '{1'b0, 2'h0, 1'b1, 1'b0, 16'hFFF8, 18'h0};
		req_valid_i <= 1'b1;
		@(posedge core_clk_i);
		#1 req_valid_i <= 1'b0;
		@(posedge core_clk_i);
		#1 rstn_i = 1'b0;
		#1 chk(out_en_n_o === 1'b1 && addr_capture_gate_o === 1'b1 && rsp_valid_o === 1'b0, "pins in reset");
		repeat (2) @(posedge core_clk_i);
		#1 rstn_i = 1'b1;
		$display("test reset done");
		repeat (60) begin
			seed = xs(seed);
			xfer(seed[0], seed[3:1], seed[5:4]);
		end
		$display("test mixed done");
		finish_test();
	end
	initial begin
		#(40 * 5000);
		fails++;
		finish_test();
	end
endmodule : tb_latched_address_sram_port
bind lasp_host lasp_chk u_chk (.*);
`default_nettype wire
